// *** rtl/csb_pkg.sv ***
// Shared constants, types and helpers of the core system bus master port
// Behaviour
// - Separate 64-bit read and write data buses
// - At most sixteen transactions outstanding
// - Single read drives address 35:3, enables
// - Address driven early, held past ready
// - Address valid whenever address/control are valid
// - Write flag low reads, high writes
// - Fetch flag on uncached fetch, fetch bursts
// - Read data sampled from clock after ready
// - Single read error with data valid
// - Write data with address when the data unit is free, else once it frees, held past ready
// - Next write data waits for ready
// - Write error one clock after ready
// - Burst read: four beats, aligned block
// - Burst order sequential or subblock XOR
// - Burst flag through burst address phase
// - First flag with first burst address
// - Last flag with final burst address
// - Burst read captures each valid beat
// - Burst beat error with its data
// - Burst write only for full block
// - Burst write starts at subblock zero
// - Burst write words advance after ready
package csb_pkg;

  localparam int ADDR_HI  = 35;
  localparam int ADDR_LO  = 3;
  localparam int DATA_W   = 64;
  localparam int BE_W     = 8;
  localparam int BEATS    = 4;
  localparam int MAX_OUT  = 16;
  localparam int MEM_WORDS = 256;

  localparam logic [1:0]      SUB_ZERO  = 2'h0;
  localparam logic [1:0]      SUB_LAST  = 2'h3;
  localparam logic [1:0]      SUB_PENUL = 2'h2;
  localparam logic [BE_W-1:0] BE_FULL   = 8'hFF;
  localparam logic [3:0]      MASK_FULL = 4'hF;
  localparam logic [DATA_W-1:0] DATA_RST = 64'h0000000000000000;

  typedef logic [ADDR_HI:ADDR_LO] csb_addr_t;
  typedef logic [DATA_W-1:0]      csb_data_t;
  typedef logic [BE_W-1:0]        csb_be_t;

  typedef enum logic [1:0] {
    CSB_RD,
    CSB_BRD,
    CSB_WR
  } csb_kind_e;

  // Subblock index of beat k for a given start and order
  function automatic logic [1:0] csb_beat_sub(input logic [1:0] start,
                                              input logic [1:0] k,
                                              input logic       sblk);
    logic [1:0] s;
    s = 2'(start + k);
    return sblk ? (start ^ k) : s;
  endfunction

endpackage

// *** rtl/csb_if.sv ***
// Pin bundle between the core bus master and the system side
interface csb_if;
  logic [35:3] bus_address;
  logic [7:0]  byte_enables;
  logic        address_valid;
  logic        address_ready;
  logic        write_flag;
  logic        instruction_fetch_flag;
  logic        burst_flag;
  logic        burst_first_flag;
  logic        burst_last_flag;
  logic        subblock_order_select;
  logic [63:0] read_data_bus;
  logic        read_data_valid;
  logic        read_bus_error;
  logic [63:0] write_data_bus;
  logic        write_data_ready;
  logic        write_bus_error;

  modport core (
    output bus_address, byte_enables, address_valid, write_flag,
    output instruction_fetch_flag, burst_flag, burst_first_flag, burst_last_flag,
    output write_data_bus,
    input  address_ready, subblock_order_select, read_data_bus, read_data_valid,
    input  read_bus_error, write_data_ready, write_bus_error
  );

  modport sys (
    input  bus_address, byte_enables, address_valid, write_flag,
    input  instruction_fetch_flag, burst_flag, burst_first_flag, burst_last_flag,
    input  write_data_bus,
    output address_ready, subblock_order_select, read_data_bus, read_data_valid,
    output read_bus_error, write_data_ready, write_bus_error
  );
endinterface

// *** rtl/csb_sys.sv ***
// System-side end: small memory answering the core bus in order
module csb_sys #(
  parameter int DEPTH = csb_pkg::MEM_WORDS,
  parameter int QD    = csb_pkg::MAX_OUT
) (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_i,
  // Core bus
  csb_if.sys        bus,
  // Pacing and error injection
  input  wire logic sblk_i,
  input  wire logic ar_stall_i,
  input  wire logic rd_stall_i,
  input  wire logic wr_stall_i,
  input  wire logic rd_err_i,
  input  wire logic wr_err_i,
  // Status
  output logic      wr_commit_o
);
  localparam int IW = $clog2(DEPTH);
  localparam int QW = $clog2(QD);

  if (DEPTH < 4 || (1 << IW) != DEPTH || QD < 2 || (1 << QW) != QD) begin : g_chk
    $error("csb_sys: DEPTH and QD must be powers of two");
  end

  csb_pkg::csb_data_t mem [DEPTH];
  csb_pkg::csb_addr_t raq [QD];
  logic [IW+8-1:0]    waq [QD];
  logic [QW-1:0]      rwp_reg, rrp_reg, wwp_reg, wrp_reg;
  logic [QW:0]        rcnt_reg, wcnt_reg;
  logic               ar_reg, rv_reg, rerr_reg, wdr_reg, werr_reg, sblk_reg, commit_reg;
  csb_pkg::csb_data_t rdata_reg;
  logic               acc, rpush, wpush, rpop, wpop, room;
  logic [IW-1:0]      widx;

  assign bus.address_ready         = ar_reg;
  assign bus.read_data_valid       = rv_reg;
  assign bus.read_data_bus         = rdata_reg;
  assign bus.read_bus_error        = rerr_reg;
  assign bus.write_data_ready      = wdr_reg;
  assign bus.write_bus_error       = werr_reg;
  assign bus.subblock_order_select = sblk_reg;
  assign wr_commit_o               = commit_reg;

  always_comb begin
    acc   = bus.address_valid && ar_reg;
    rpush = acc && !bus.write_flag;
    wpush = acc && bus.write_flag;
    rpop  = (rcnt_reg != '0) && !rd_stall_i;
    wpop  = wdr_reg;
    // Full queue depth usable: a ready pulse and its push never overlap the next pulse
    room  = (rcnt_reg < (QW+1)'(QD)) && (wcnt_reg < (QW+1)'(QD));
    widx  = waq[wrp_reg][IW-1:0];
  end

  // Address acceptance paced by ready pulses
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ar_reg   <= 1'b0;
      sblk_reg <= 1'b0;
    end else begin
      ar_reg   <= bus.address_valid && !ar_reg && !ar_stall_i && room;
      sblk_reg <= sblk_i;
    end
  end

  // Read queue: one data beat per accepted address beat, in order
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rwp_reg   <= '0;
      rrp_reg   <= '0;
      rcnt_reg  <= '0;
      rv_reg    <= 1'b0;
      rerr_reg  <= 1'b0;
      rdata_reg <= csb_pkg::DATA_RST;
    end else begin
      if (rpush) begin
        raq[rwp_reg] <= bus.bus_address;
        rwp_reg      <= rwp_reg + 1'b1;
      end
      rv_reg   <= rpop;
      rerr_reg <= rpop && rd_err_i;
      if (rpop) begin
        rdata_reg <= mem[raq[rrp_reg][IW+2:3]];
        rrp_reg   <= rrp_reg + 1'b1;
      end
      rcnt_reg <= (QW+1)'(rcnt_reg + rpush - rpop);
    end
  end

  // Write queue: data taken in the clock the ready is seen
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wwp_reg    <= '0;
      wrp_reg    <= '0;
      wcnt_reg   <= '0;
      wdr_reg    <= 1'b0;
      werr_reg   <= 1'b0;
      commit_reg <= 1'b0;
    end else begin
      if (wpush) begin
        waq[wwp_reg] <= {bus.byte_enables, bus.bus_address[IW+2:3]};
        wwp_reg      <= wwp_reg + 1'b1;
      end
      wdr_reg    <= (wcnt_reg != '0) && !wdr_reg && !wr_stall_i;
      werr_reg   <= wdr_reg && wr_err_i;
      commit_reg <= wpop;
      if (wpop) begin
        for (int b = 0; b < 8; b++) begin
          if (waq[wrp_reg][IW+b]) begin
            mem[widx][8*b +: 8] <= bus.write_data_bus[8*b +: 8];
          end
        end
        wrp_reg <= wrp_reg + 1'b1;
      end
      wcnt_reg <= (QW+1)'(wcnt_reg + wpush - wpop);
    end
  end

endmodule // csb_sys

// *** rtl/csb_core.sv ***
// Core-side end: bus master issuing single and burst transfers
module csb_core #(
  parameter int OUT_MAX = csb_pkg::MAX_OUT
) (
  // Clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 rst_i,
  // Core bus
  csb_if.core                       bus,
  // Request
  input  wire logic                 req_valid_i,
  input  csb_pkg::csb_kind_e        req_kind_i,
  input  wire csb_pkg::csb_addr_t   req_addr_i,
  input  wire csb_pkg::csb_be_t     req_be_i,
  input  wire logic                 req_instr_i,
  input  wire logic [3:0]           req_wmask_i,
  input  wire csb_pkg::csb_data_t [3:0] req_wdata_i,
  output logic                      req_ready_o,
  // Read answers
  output logic                      rd_valid_o,
  output csb_pkg::csb_data_t        rd_data_o,
  output logic                      rd_err_o,
  output logic                      rd_last_o,
  // Write answers
  output logic                      wr_resp_o,
  output logic                      wr_err_o,
  // Status
  output logic [$clog2(OUT_MAX):0]  outstanding_o
);
  localparam int PW = $clog2(OUT_MAX);

  if (OUT_MAX < 2 || OUT_MAX > csb_pkg::MAX_OUT || (1 << PW) != OUT_MAX) begin : g_chk
    $error("csb_core: OUT_MAX must be a power of two up to the bus limit");
  end

  typedef enum {A_IDLE, A_WAIT, A_ADDR, A_HOLD} csb_astate_e;

  // Lowest pending word of a partial write buffer
  function automatic logic [1:0] csb_low(input logic [3:0] m);
    logic [1:0] r;
    r = 2'h3;
    for (int i = 3; i >= 0; i--) begin
      if (m[i]) r = 2'(i);
    end
    return r;
  endfunction

  csb_astate_e              a_state;
  logic                     ready_reg;
  csb_pkg::csb_kind_e       slot_kind;
  csb_pkg::csb_addr_t       slot_addr;
  csb_pkg::csb_be_t         slot_be;
  logic                     slot_instr, slot_burst;
  logic [3:0]               slot_mask;
  csb_pkg::csb_data_t [3:0] slot_data;

  logic                     av_reg, wr_reg, instr_reg, burst_reg, first_reg, last_reg;
  csb_pkg::csb_addr_t       addr_reg;
  csb_pkg::csb_be_t         be_reg;
  logic [1:0]               ab_reg, st_reg;
  logic                     sb_reg, dl_reg;
  logic [PW:0]              oc_reg;

  logic                     wbusy_reg, wdr_d_reg, wresp_reg, werr_reg;
  logic [1:0]               wi_reg, wn_reg;
  csb_pkg::csb_data_t [3:0] wbuf_reg;
  csb_pkg::csb_data_t       wd_reg;

  logic                     rq [OUT_MAX];
  logic [PW-1:0]            rwp_reg, rrp_reg;
  logic [PW:0]              rcnt_reg;
  logic [1:0]               rb_reg;
  logic                     rv_reg, rerr_reg, rlast_reg;
  csb_pkg::csb_data_t       rdata_reg;

  logic                     is_wr, start, a_acc, a_end, wfree, wdone, wload, tx_done, more;
  logic                     enq, beat, blast;
  logic [1:0]               idx;
  logic [3:0]               mask_rest;
  csb_pkg::csb_addr_t       start_addr;

  assign bus.bus_address            = addr_reg;
  assign bus.byte_enables           = be_reg;
  assign bus.address_valid          = av_reg;
  assign bus.write_flag             = wr_reg;
  assign bus.instruction_fetch_flag = instr_reg;
  assign bus.burst_flag             = burst_reg;
  assign bus.burst_first_flag       = first_reg;
  assign bus.burst_last_flag        = last_reg;
  assign bus.write_data_bus         = wd_reg;
  assign req_ready_o                = ready_reg;
  assign rd_valid_o                 = rv_reg;
  assign rd_data_o                  = rdata_reg;
  assign rd_err_o                   = rerr_reg;
  assign rd_last_o                  = rlast_reg;
  assign wr_resp_o                  = wresp_reg;
  assign wr_err_o                   = werr_reg;
  assign outstanding_o              = oc_reg;

  always_comb begin
    is_wr     = (slot_kind == csb_pkg::CSB_WR);
    idx       = csb_low(slot_mask);
    mask_rest = slot_mask & ~(4'h1 << idx);
    start     = (a_state == A_WAIT) && (oc_reg < (PW+1)'(OUT_MAX));
    a_acc     = (a_state == A_ADDR) && bus.address_ready;
    a_end     = a_acc && (!burst_reg || ab_reg == csb_pkg::SUB_LAST);
    wdone     = wbusy_reg && bus.write_data_ready && (wi_reg == wn_reg);
    wfree     = !wbusy_reg || wdone;
    wload     = is_wr && wfree &&
                (start || ((a_state == A_ADDR || a_state == A_HOLD) && !dl_reg));
    tx_done   = (a_end && !(is_wr && !dl_reg && !wload)) || (a_state == A_HOLD && wload);
    more      = is_wr && !slot_burst && (mask_rest != 4'h0);
    enq       = a_acc && !wr_reg && (ab_reg == csb_pkg::SUB_ZERO);
    beat      = (rcnt_reg != '0) && bus.read_data_valid;
    blast     = !rq[rrp_reg] || (rb_reg == csb_pkg::SUB_LAST);
    if (slot_kind == csb_pkg::CSB_WR) begin
      start_addr = {slot_addr[35:5], slot_burst ? csb_pkg::SUB_ZERO : idx};
    end else begin
      start_addr = slot_addr;
    end
  end

  // Request slot and transaction sequencing
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      a_state    <= A_IDLE;
      ready_reg  <= 1'b1;
      slot_kind  <= csb_pkg::CSB_RD;
      slot_addr  <= '0;
      slot_be    <= '0;
      slot_instr <= 1'b0;
      slot_burst <= 1'b0;
      slot_mask  <= 4'h0;
      slot_data  <= '0;
    end else begin
      case (a_state)
        A_IDLE: begin
          if (req_valid_i && ready_reg) begin
            slot_kind  <= req_kind_i;
            slot_addr  <= req_addr_i;
            slot_be    <= req_be_i;
            slot_instr <= req_instr_i;
            slot_mask  <= (req_kind_i == csb_pkg::CSB_WR) ? req_wmask_i : 4'h1;
            slot_data  <= req_wdata_i;
            slot_burst <= (req_kind_i == csb_pkg::CSB_BRD) ||
                          ((req_kind_i == csb_pkg::CSB_WR) &&
                           (req_wmask_i == csb_pkg::MASK_FULL) &&
                           (req_be_i == csb_pkg::BE_FULL));
            ready_reg  <= 1'b0;
            a_state    <= A_WAIT;
          end
        end
        A_WAIT: begin
          if (start) a_state <= A_ADDR;
        end
        A_ADDR, A_HOLD: begin
          if (tx_done) begin
            slot_mask <= mask_rest;
            if (more) begin
              a_state <= A_WAIT;
            end else begin
              a_state   <= A_IDLE;
              ready_reg <= 1'b1;
            end
          end else if (a_end) begin
            a_state <= A_HOLD;
          end
        end
        default: a_state <= A_IDLE;
      endcase
    end
  end

  // Address phase: held until the clock after ready is seen
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      av_reg    <= 1'b0;
      addr_reg  <= '0;
      be_reg    <= '0;
      wr_reg    <= 1'b0;
      instr_reg <= 1'b0;
      burst_reg <= 1'b0;
      first_reg <= 1'b0;
      last_reg  <= 1'b0;
      ab_reg    <= csb_pkg::SUB_ZERO;
      st_reg    <= csb_pkg::SUB_ZERO;
      sb_reg    <= 1'b0;
    end else if (start) begin
      av_reg    <= 1'b1;
      addr_reg  <= start_addr;
      be_reg    <= slot_burst ? csb_pkg::BE_FULL : slot_be;
      wr_reg    <= is_wr;
      instr_reg <= slot_instr && !is_wr;
      burst_reg <= slot_burst;
      first_reg <= slot_burst;
      last_reg  <= 1'b0;
      ab_reg    <= csb_pkg::SUB_ZERO;
      st_reg    <= start_addr[4:3];
      sb_reg    <= bus.subblock_order_select;
    end else if (a_acc) begin
      if (burst_reg && ab_reg != csb_pkg::SUB_LAST) begin
        ab_reg         <= ab_reg + 1'b1;
        addr_reg[4:3]  <= csb_pkg::csb_beat_sub(st_reg, 2'(ab_reg + 1'b1), sb_reg);
        first_reg      <= 1'b0;
        last_reg       <= (ab_reg == csb_pkg::SUB_PENUL);
      end else begin
        av_reg    <= 1'b0;
        wr_reg    <= 1'b0;
        instr_reg <= 1'b0;
        burst_reg <= 1'b0;
        first_reg <= 1'b0;
        last_reg  <= 1'b0;
      end
    end
  end

  // Write data unit: one transaction's words at a time
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wbusy_reg <= 1'b0;
      wi_reg    <= csb_pkg::SUB_ZERO;
      wn_reg    <= csb_pkg::SUB_ZERO;
      wbuf_reg  <= '0;
      wd_reg    <= csb_pkg::DATA_RST;
      dl_reg    <= 1'b0;
    end else begin
      if (start) begin
        dl_reg <= wload;
      end else if (wload) begin
        dl_reg <= 1'b1;
      end
      if (wload) begin
        wbusy_reg <= 1'b1;
        wbuf_reg  <= slot_data;
        wi_reg    <= slot_burst ? csb_pkg::SUB_ZERO : idx;
        wn_reg    <= slot_burst ? csb_pkg::SUB_LAST : idx;
        wd_reg    <= slot_burst ? slot_data[0] : slot_data[idx];
      end else if (wbusy_reg && bus.write_data_ready) begin
        if (wi_reg == wn_reg) begin
          wbusy_reg <= 1'b0;
        end else begin
          wi_reg <= wi_reg + 1'b1;
          wd_reg <= wbuf_reg[2'(wi_reg + 1'b1)];
        end
      end
    end
  end

  // Write answers: error comes one clock after the ready
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wdr_d_reg <= 1'b0;
      wresp_reg <= 1'b0;
      werr_reg  <= 1'b0;
    end else begin
      wdr_d_reg <= wbusy_reg && bus.write_data_ready;
      wresp_reg <= wdr_d_reg;
      werr_reg  <= wdr_d_reg && bus.write_bus_error;
    end
  end

  // Read tracking: burst beats counted per queued read
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rwp_reg   <= '0;
      rrp_reg   <= '0;
      rcnt_reg  <= '0;
      rb_reg    <= csb_pkg::SUB_ZERO;
      rv_reg    <= 1'b0;
      rerr_reg  <= 1'b0;
      rlast_reg <= 1'b0;
      rdata_reg <= csb_pkg::DATA_RST;
    end else begin
      if (enq) begin
        rq[rwp_reg] <= burst_reg;
        rwp_reg     <= rwp_reg + 1'b1;
      end
      rv_reg    <= beat;
      rlast_reg <= beat && blast;
      rerr_reg  <= beat && bus.read_bus_error;
      if (beat) begin
        rdata_reg <= bus.read_data_bus;
        rb_reg    <= blast ? csb_pkg::SUB_ZERO : 2'(rb_reg + 1'b1);
        if (blast) rrp_reg <= rrp_reg + 1'b1;
      end
      rcnt_reg <= (PW+1)'(rcnt_reg + enq - (beat && blast));
    end
  end

  // Outstanding count: taken at first drive, dropped at last data
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      oc_reg <= '0;
    end else begin
      oc_reg <= (PW+1)'(oc_reg + start - (beat && blast) - wdone);
    end
  end

endmodule // csb_core

// *** verification/csb_bus_asserts.sv ***
// Concurrent checks on the core system bus pins
module csb_bus_asserts (
  // Clock and reset
  input wire logic        mclk_i,
  input wire logic        rst_i,
  // Address phase
  input wire logic [35:3] bus_address,
  input wire logic        address_valid,
  input wire logic        address_ready,
  input wire logic        write_flag,
  input wire logic        burst_flag,
  input wire logic        burst_first_flag,
  input wire logic        burst_last_flag,
  input wire logic        subblock_order_select,
  // Data phase
  input wire logic        read_data_valid,
  input wire logic        read_bus_error,
  input wire logic        write_data_ready,
  input wire logic        write_bus_error
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  logic [1:0] beat_cnt;
  logic [1:0] start_q;
  logic       sblk_q;
  logic [1:0] exp_sub;

  // Counter cleared whenever burst flag is low, so each burst counts from beat 0
  always_ff @(posedge mclk_i) begin
    if (rst_i || !burst_flag) beat_cnt <= 2'h0;
    else if (address_valid && address_ready) beat_cnt <= beat_cnt + 2'h1;
  end
  always_ff @(posedge mclk_i) begin
    if (burst_first_flag) begin
      start_q <= bus_address[4:3];
      sblk_q  <= subblock_order_select;
    end
  end
  assign exp_sub = sblk_q ? (start_q ^ beat_cnt) : 2'(start_q + beat_cnt);

  property p_hold;
    address_valid && !address_ready |=> address_valid && $stable(bus_address)
      && $stable(write_flag) && $stable(burst_flag);
  endproperty
  property p_rdy;    address_ready |-> address_valid; endproperty
  property p_bav;    burst_first_flag || burst_last_flag |-> address_valid && burst_flag; endproperty
  property p_cont;
    address_valid && burst_flag && address_ready && !burst_last_flag |=> address_valid && burst_flag;
  endproperty
  property p_first;  address_valid && burst_flag |-> burst_first_flag == (beat_cnt == 2'h0); endproperty
  property p_last;   address_valid && burst_flag |-> burst_last_flag == (beat_cnt == 2'h3); endproperty
  property p_order;  address_valid && burst_flag && !burst_first_flag |-> bus_address[4:3] == exp_sub;
  endproperty
  property p_wstart; burst_first_flag && write_flag |-> bus_address[4:3] == 2'h0; endproperty
  property p_rberr;  read_bus_error |-> read_data_valid; endproperty
  property p_wberr;  write_bus_error |-> $past(write_data_ready); endproperty

  a_hold:   assert property (p_hold) else $error("address phase changed before ready");
  a_rdy:    assert property (p_rdy) else $error("ready without valid address");
  a_bav:    assert property (p_bav) else $error("burst marker outside address phase");
  a_cont:   assert property (p_cont) else $error("burst address phase broken");
  a_first:  assert property (p_first) else $error("first marker on wrong beat");
  a_last:   assert property (p_last) else $error("last marker on wrong beat");
  a_order:  assert property (p_order) else $error("burst word order wrong");
  a_wstart: assert property (p_wstart) else $error("write burst not at word zero");
  a_rberr:  assert property (p_rberr) else $error("read error without data valid");
  a_wberr:  assert property (p_wberr) else $error("write error not after ready");

  c_brd: cover property (burst_first_flag && !write_flag && subblock_order_select);
  c_bwr: cover property (burst_last_flag && write_flag && address_ready);
  c_err: cover property (read_bus_error);
endmodule // csb_bus_asserts

// *** verification/core_system_bus_master_bench.sv ***
// Bench joining both bus ends, driving core requests and system pacing
module core_system_bus_master_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic                       mclk_i, rst_i, req_valid, req_instr, req_ready;
  csb_pkg::csb_kind_e         req_kind;
  csb_pkg::csb_addr_t         req_addr;
  logic [7:0]                 req_be;
  logic [3:0]                 req_wmask;
  csb_pkg::csb_data_t [3:0]   req_wdata;
  logic                       sblk, ar_st, rd_st, wr_st, rd_er, wr_er;
  logic                       rd_valid, rd_err, rd_last, wr_resp, wr_err, wr_commit;
  csb_pkg::csb_data_t         rd_data;
  logic [4:0]                 outstanding;
  logic [63:0]                exp_mem [0:15];
  int                         miscompares, checks_done, commits;

  csb_if csb_bus ();
  csb_core csb_core_i (.mclk_i(mclk_i), .rst_i(rst_i), .bus(csb_bus),
    .req_valid_i(req_valid), .req_kind_i(req_kind), .req_addr_i(req_addr),
    .req_be_i(req_be), .req_instr_i(req_instr), .req_wmask_i(req_wmask),
    .req_wdata_i(req_wdata), .req_ready_o(req_ready), .rd_valid_o(rd_valid),
    .rd_data_o(rd_data), .rd_err_o(rd_err), .rd_last_o(rd_last),
    .wr_resp_o(wr_resp), .wr_err_o(wr_err), .outstanding_o(outstanding));
  csb_sys csb_sys_i (.mclk_i(mclk_i), .rst_i(rst_i), .bus(csb_bus), .sblk_i(sblk),
    .ar_stall_i(ar_st), .rd_stall_i(rd_st), .wr_stall_i(wr_st), .rd_err_i(rd_er),
    .wr_err_i(wr_er), .wr_commit_o(wr_commit));
  csb_bus_asserts csb_bus_asserts_i (.mclk_i(mclk_i), .rst_i(rst_i),
    .bus_address(csb_bus.bus_address), .address_valid(csb_bus.address_valid),
    .address_ready(csb_bus.address_ready), .write_flag(csb_bus.write_flag),
    .burst_flag(csb_bus.burst_flag), .burst_first_flag(csb_bus.burst_first_flag),
    .burst_last_flag(csb_bus.burst_last_flag),
    .subblock_order_select(csb_bus.subblock_order_select),
    .read_data_valid(csb_bus.read_data_valid), .read_bus_error(csb_bus.read_bus_error),
    .write_data_ready(csb_bus.write_data_ready), .write_bus_error(csb_bus.write_bus_error));

  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  // Stored write words, counted on the system side
  always @(posedge mclk_i) begin
    if (rst_i) commits <= 0;
    else if (wr_commit === 1'b1) commits <= commits + 1;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] expv);
    checks_done++;
    if (seen !== expv) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, expv, seen);
    end
  endtask

  // Outputs read at the edge itself hold the settled value of the cycle before
  task automatic wait_for(input int sel);
    int n;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (!(sel == 0 ? req_ready === 1'b1 : sel == 1 ? csb_bus.address_valid === 1'b1 :
                 sel == 2 ? rd_valid === 1'b1 : wr_resp === 1'b1) && n < 200);
    if (n == 200) begin
      miscompares++;
      finish_test();
    end
  endtask

  task automatic send(input csb_pkg::csb_kind_e k, input int w, input logic [7:0] be,
                      input logic ins, input logic [3:0] m, input bit chk);
    int b;
    b = w & 32'hFFFFFFFC;
    @(posedge mclk_i);
    req_valid <= 1'b1;
    req_kind  <= k;
    req_addr  <= csb_pkg::csb_addr_t'(w);
    req_be    <= be;
    req_instr <= ins;
    req_wmask <= m;
    for (int i = 0; i < 4; i++) req_wdata[i] <= exp_mem[b + i];
    wait_for(0);
    req_valid <= 1'b0;
    if (chk) begin
      wait_for(1);
      check("address", 64'(csb_bus.bus_address), 64'(k == csb_pkg::CSB_WR ? b : w));
      if (k != csb_pkg::CSB_BRD) check("enables", 64'(csb_bus.byte_enables), 64'(be));
      check("write_flag", 64'(csb_bus.write_flag), 64'(k == csb_pkg::CSB_WR));
      check("fetch", 64'(csb_bus.instruction_fetch_flag), 64'(ins && k != csb_pkg::CSB_WR));
      check("burst", 64'(csb_bus.burst_flag),
            64'(k == csb_pkg::CSB_BRD || (k == csb_pkg::CSB_WR && m == 4'hF)));
    end
  endtask

  task automatic get_rd(input int w, input logic er, input logic last);
    wait_for(2);
    check("rd_data", rd_data, exp_mem[w]);
    check("rd_err", 64'(rd_err), 64'(er));
    check("rd_last", 64'(rd_last), 64'(last));
  endtask

  task automatic get_wr(input logic er);
    wait_for(3);
    check("wr_err", 64'(wr_err), 64'(er));
  endtask

  initial begin
    miscompares = 0;
    checks_done = 0;
    {req_valid, req_instr, req_be, req_wmask, sblk, ar_st, rd_st, wr_st, rd_er, wr_er} = '0;
    req_kind  = csb_pkg::CSB_RD;
    req_addr  = '0;
    req_wdata = '0;
    for (int i = 0; i < 16; i++) exp_mem[i] = {32'hC0DE0000, 32'(i)};
    rst_i = 1'b1;
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    // Full block drained as one burst while write ready is held off
    wr_st <= 1'b1;
    send(csb_pkg::CSB_WR, 0, 8'hFF, 1'b0, 4'hF, 1'b1);
    repeat (4) @(posedge mclk_i);
    wr_st <= 1'b0;
    repeat (4) get_wr(1'b0);
    $display("test burst_write done");
    // Every start word in both orders; last case carries a bus error
    for (int sb = 0; sb < 2; sb++) begin
      for (int s = 0; s < 4; s++) begin
        sblk  <= 1'(sb);
        rd_er <= (sb == 1 && s == 3);
        send(csb_pkg::CSB_BRD, s, 8'hFF, 1'(s), 4'h0, 1'b1);
        for (int k = 0; k < 4; k++)
          get_rd(sb ? (s ^ k) : ((s + k) & 3), sb == 1 && s == 3, k == 3);
      end
    end
    rd_er <= 1'b0;
    $display("test burst_read done");
    // Partial masks become single writes; second waits behind busy data unit
    exp_mem[4] = 64'hFEED000000000004;
    exp_mem[6] = 64'hFEED000000000006;
    wr_er <= 1'b1;
    send(csb_pkg::CSB_WR, 4, 8'hFF, 1'b0, 4'h5, 1'b1);
    repeat (2) get_wr(1'b1);
    wr_er <= 1'b0;
    exp_mem[8] = 64'hBEEF000000000008;
    exp_mem[9] = 64'hBEEF000000000009;
    wr_st <= 1'b1;
    send(csb_pkg::CSB_WR, 8, 8'hFF, 1'b0, 4'h3, 1'b1);
    repeat (3) @(posedge mclk_i);
    wr_st <= 1'b0;
    repeat (2) get_wr(1'b0);
    check("commits", 64'(commits), 64'h8);
    for (int i = 0; i < 4; i++) begin
      send(csb_pkg::CSB_RD, i < 2 ? 4 + 2 * i : 6 + i, 8'hFF, 1'b1, 4'h0, 1'b1);
      get_rd(i < 2 ? 4 + 2 * i : 6 + i, 1'b0, 1'b1);
    end
    $display("test single_write done");
    // Address driven before ready; error returned with the data
    ar_st <= 1'b1;
    rd_er <= 1'b1;
    send(csb_pkg::CSB_RD, 6, 8'h0F, 1'b0, 4'h0, 1'b1);
    repeat (5) @(posedge mclk_i);
    ar_st <= 1'b0;
    get_rd(6, 1'b1, 1'b1);
    rd_er <= 1'b0;
    $display("test stalled_read done");
    // Seventeen reads against a stalled read queue: only sixteen go out
    rd_st <= 1'b1;
    for (int i = 0; i < 17; i++) send(csb_pkg::CSB_RD, i % 4, 8'hFF, 1'b0, 4'h0, 1'b0);
    repeat (10) @(posedge mclk_i);
    check("outstanding", 64'(outstanding), 64'h10);
    rd_st <= 1'b0;
    for (int i = 0; i < 17; i++) get_rd(i % 4, 1'b0, 1'b1);
    $display("test outstanding done");
    finish_test();
  end
endmodule // core_system_bus_master_bench
